// [dv/fmm_host_model.sv]
`timescale 1ns/10ps
module fmm_host_model (
	// Commands from the bench
	input  wire logic applyTest,
	input  wire logic intHigh,
	// Pins toward the device
	output logic      testHighVoltage,
	output logic      intPinLevel
);
	// Test voltage only when the host asks for it
	assign testHighVoltage = applyTest;
	// Interrupt pin level held by the host
	assign intPinLevel     = intHigh;
endmodule

// [dv/forced_monitor_mode_entry_tb.sv]
`timescale 1ns/10ps
module forced_monitor_mode_entry_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic               clk_sys         = 1'b0;
	logic               nrst            = 1'b0;
	logic               otherRst_n      = 1'b1;
	logic               applyTest       = 1'b0;
	logic               intHigh         = 1'b0;
	logic               cfgIntPinEnable = 1'b0;
	logic               vecFetch        = 1'b0;
	logic               vecLowByte      = 1'b0;
	logic               blank           = 1'b1;
	logic [1:0]         vecKind         = 2'h0;
	logic [7:0]         portARaw        = 8'h00;
	logic [15:0]        lfsr            = 16'hF7BB;
	logic               testHighVoltage;
	logic               intPinLevel;
	logic               coreReset;
	logic               intPinForBranch;
	logic [15:0]        memAddr;
	logic [3:0]         oscTrim;
	logic [7:0]         portARead;
	fmm_pkg::fmm_mode_t mode;
	fmm_pkg::fmm_pins_t pins;
	int                 n_errors        = 0;
	int                 checks          = 0;
	// Flash reads erased until the vector is programmed
	wire logic [7:0]    memData         = blank ? 8'hFF : 8'h5A;

	// Bus clock, 100 ns period
	always #50 clk_sys = ~clk_sys;

	fmm_host_model host (.applyTest(applyTest), .intHigh(intHigh), .testHighVoltage(testHighVoltage),
		.intPinLevel(intPinLevel));

	fmm_entry dut (.clk_sys(clk_sys), .nrst(nrst), .otherRst_n(otherRst_n), .testHighVoltage(testHighVoltage),
		.intPinLevel(intPinLevel), .cfgIntPinEnable(cfgIntPinEnable), .startupStrapPinA(lfsr[10]),
		.startupStrapPinB(lfsr[11]), .memData(memData), .vecFetch(vecFetch), .vecKind(vecKind),
		.vecLowByte(vecLowByte), .portARaw(portARaw), .memAddr(memAddr), .coreReset(coreReset),
		.mode(mode), .pins(pins), .oscTrim(oscTrim), .portARead(portARead), .intPinForBranch(intPinForBranch));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] nextLfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Pin defaults in forced monitor mode
	function automatic fmm_pkg::fmm_pins_t expPins(input logic hi);
		fmm_pkg::fmm_pins_t p;
		p.pinInputOnly = hi ? 6'h1E : 6'h3E;
		p.serialEn     = 1'b1;
		p.extClockEn   = hi;
		return p;
	endfunction

	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic complete_run();
		$display("n_errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Pulse a non power-on reset and count cycles until the core runs
	task automatic runReset(output int n);
		@(negedge clk_sys) otherRst_n = 1'b0;
		@(negedge clk_sys) otherRst_n = 1'b1;
		for (n = 0; n < 60 && coreReset !== 1'b0; n++) @(negedge clk_sys);
		check(coreReset === 1'b0, "core reset never released");
	endtask

	// Reset and trap vector kinds (0 and 1), both bytes, from the given page
	task automatic checkVec(input logic [7:0] page);
		for (int k = 0; k < 4; k++) begin
			@(negedge clk_sys);
			vecFetch   = 1'b1;
			vecKind    = {1'b0, k[1]};
			vecLowByte = k[0];
			#10;
			check(memAddr === {page, (k[1] ? 8'hFC : 8'hFE) | {7'h00, k[0]}}, "vector address");
		end
		@(negedge clk_sys) vecFetch = 1'b0;
	endtask

	// Random pin traffic while in monitor mode
	task automatic checkMon(input logic forced);
		for (int k = 0; k < 8; k++) begin
			@(negedge clk_sys);
			lfsr            = nextLfsr(lfsr);
			portARaw        = lfsr[7:0];
			intHigh         = lfsr[8];
			cfgIntPinEnable = lfsr[9];
			#10;
			check(mode.monitorMode === 1'b1 && mode.forcedMonitor === forced, "mode flags");
			check(portARead === (portARaw & 8'hFB), "port A bit 2");
			check(intPinForBranch === intPinLevel, "branch pin sense");
			if (forced) begin
				check(mode.watchdogDisable === 1'b1, "watchdog not disabled");
				check(mode.strapCheckEn === 1'b0, "strap check enforced");
				check(pins === expPins(intHigh), "pin defaults");
				check(oscTrim === fmm_pkg::OSC_TRIM_DEF && mode.oscDefault === 1'b1, "oscillator");
			end
		end
		checkVec(fmm_pkg::MON_PAGE);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int cb;
		int cu;
		repeat (6) @(negedge clk_sys);
		nrst = 1'b1;
		runReset(cb);
		checkMon(1'b1);
		runReset(cu);
		checkMon(1'b1);
		@(negedge clk_sys) nrst = 1'b0;
		blank = 1'b0;
		@(negedge clk_sys) nrst = 1'b1;
		runReset(cu);
		check(mode.monitorMode === 1'b0 && mode.forcedMonitor === 1'b0, "not user mode");
		check(pins === '0 && mode.watchdogDisable === 1'b0 && portARead === portARaw, "user outputs");
		checkVec(fmm_pkg::USER_PAGE);
		check(cb > cu, "no extra reset cycle");
		applyTest = 1'b1;
		runReset(cu);
		checkMon(1'b0);
		complete_run();
	end

	// Watchdog well past the expected run length
	initial begin
		#100000;
		n_errors++;
		complete_run();
	end
endmodule

// [rtl/fmm_entry.sv]
`timescale 1ns/10ps
module fmm_entry (
	// Clock and power-on reset
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	// Other reset sources (pin, watchdog, etc.), active low pulse level
	input  wire logic               otherRst_n,
	// Interrupt pin sensing
	input  wire logic               testHighVoltage,
	input  wire logic               intPinLevel,
	input  wire logic               cfgIntPinEnable,
	// Startup strap pins
	input  wire logic               startupStrapPinA,
	input  wire logic               startupStrapPinB,
	// Vector fetch data from memory
	input  wire logic [7:0]         memData,
	// Vector fetch request from core
	input  wire logic               vecFetch,
	input  wire logic [1:0]         vecKind,
	input  wire logic               vecLowByte,
	// Port A raw read data
	input  wire logic [7:0]         portARaw,
	// Outputs: memory address
	output logic [15:0]             memAddr,
	// Outputs: core control
	output logic                    coreReset,
	output fmm_pkg::fmm_mode_t      mode,
	output fmm_pkg::fmm_pins_t      pins,
	output logic [3:0]              oscTrim,
	output logic [7:0]              portARead,
	output logic                    intPinForBranch
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	fmm_pkg::fmm_state_t stateReg, stateNext;
	logic [7:0] vecHiReg, vecHiNext;
	logic       forcedReg, forcedNext;
	logic       monReg, monNext;
	logic       extraDoneReg, extraDoneNext;
	logic       rstStart;
	logic       rstDone;

	fmm_reset_counter #(.CYCLES(fmm_pkg::RESET_CYCLES)) uCnt (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.start   (rstStart),
		.done    (rstDone)
	);

	// Reset sequencer and vector check
	always_comb begin
		stateNext     = stateReg;
		vecHiNext     = vecHiReg;
		forcedNext    = forcedReg;
		monNext       = monReg;
		extraDoneNext = extraDoneReg;
		rstStart      = 1'b0;
		if (!otherRst_n) begin
			stateNext = fmm_pkg::ST_RESET;
			rstStart  = 1'b1;
		end else begin
			case (stateReg)
				fmm_pkg::ST_RESET: begin
					if (rstDone) begin
						// flag or test voltage picks the mode
						monNext   = forcedReg | testHighVoltage;
						stateNext = forcedReg ? fmm_pkg::ST_RUN : fmm_pkg::ST_FETCHH;
						if (testHighVoltage) begin
							stateNext = fmm_pkg::ST_RUN;
						end
					end
				end
				fmm_pkg::ST_FETCHH: begin
					vecHiNext = memData;
					stateNext = fmm_pkg::ST_FETCHL;
				end
				fmm_pkg::ST_FETCHL: begin
					if (vecHiReg == fmm_pkg::ERASED_BYTE && memData == fmm_pkg::ERASED_BYTE) begin
						forcedNext = 1'b1;
						stateNext  = fmm_pkg::ST_INTRST;
						rstStart   = 1'b1;
					end else begin
						stateNext = fmm_pkg::ST_RUN;
					end
				end
				fmm_pkg::ST_INTRST: begin
					if (rstDone) begin
						monNext       = 1'b1;
						extraDoneNext = 1'b1;
						stateNext     = fmm_pkg::ST_RUN;
					end
				end
				fmm_pkg::ST_RUN: begin
					stateNext = fmm_pkg::ST_RUN;
				end
				default: begin
					stateNext = fmm_pkg::ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stateReg     <= fmm_pkg::ST_RESET;
			vecHiReg     <= 8'h00;
			forcedReg    <= 1'b0;
			monReg       <= 1'b0;
			extraDoneReg <= 1'b0;
		end else begin
			stateReg     <= stateNext;
			vecHiReg     <= vecHiNext;
			forcedReg    <= forcedNext;
			monReg       <= monNext;
			extraDoneReg <= extraDoneNext;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Core held in reset until sequence runs
	assign coreReset = (stateReg != fmm_pkg::ST_RUN);

	// Vector address: sequencer fetch or core fetch, page by mode
	always_comb begin
		memAddr = fmm_pkg::USER_RESET_VEC;
		if (stateReg == fmm_pkg::ST_FETCHL) begin
			memAddr = {fmm_pkg::USER_PAGE, fmm_pkg::RESET_VEC_LO | 8'h01};
		end else if (vecFetch) begin
			memAddr[15:8] = monReg ? fmm_pkg::MON_PAGE : fmm_pkg::USER_PAGE;
			memAddr[7:0]  = ((vecKind == 2'h0) ? fmm_pkg::RESET_VEC_LO : fmm_pkg::TRAP_VEC_LO) | {7'h00, vecLowByte};
		end
	end

	// Mode flags
	always_comb begin
		mode.monitorMode     = monReg;
		mode.forcedMonitor   = forcedReg;
		mode.watchdogDisable = forcedReg | (monReg & testHighVoltage);
		mode.oscDefault      = forcedReg;
		mode.strapCheckEn    = monReg & ~forcedReg;
	end

	// Pin defaults in forced monitor
	always_comb begin
		pins.pinInputOnly = '0;
		pins.serialEn     = 1'b0;
		pins.extClockEn   = 1'b0;
		if (forcedReg && monReg) begin
			pins.pinInputOnly                       = '1;
			pins.pinInputOnly[fmm_pkg::SERIAL_BIT]  = 1'b0;
			pins.serialEn                           = 1'b1;
			if (intPinLevel) begin
				pins.pinInputOnly[fmm_pkg::EXTCLK_BIT] = 1'b0;
				pins.extClockEn                        = 1'b1;
			end
		end
	end

	assign oscTrim = fmm_pkg::OSC_TRIM_DEF;

	// Port A read and branch pin view
	always_comb begin
		portARead = portARaw;
		if (monReg) begin
			portARead[fmm_pkg::IRQ_BIT] = 1'b0;
		end
		intPinForBranch = (monReg | cfgIntPinEnable) ? intPinLevel : 1'b1;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_blank_forces: assert property (@(posedge clk_sys) disable iff (!nrst)
		(stateReg == fmm_pkg::ST_FETCHL && otherRst_n && vecHiReg == 8'hFF && memData == 8'hFF)
		|=> forcedReg && stateReg == fmm_pkg::ST_INTRST) else $error("blank vector not forced");
	// Blank vector holds the core in reset for one full extra reset span
	chk_extra_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(forcedReg) |-> coreReset [*8]) else $error("extra reset skipped");
	chk_wdog_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		forcedReg |-> mode.watchdogDisable) else $error("watchdog on in forced mode");
	chk_pins_high: assert property (@(posedge clk_sys) disable iff (!nrst)
		(forcedReg && monReg && intPinLevel) |-> pins.extClockEn && pins.serialEn) else $error("pins high wrong");
	chk_pins_low: assert property (@(posedge clk_sys) disable iff (!nrst)
		(forcedReg && monReg && !intPinLevel) |-> !pins.extClockEn && pins.pinInputOnly[5]) else $error("pins low wrong");
	chk_porta_bit2: assert property (@(posedge clk_sys) disable iff (!nrst)
		monReg |-> !portARead[2]) else $error("port bit 2 not zero");
	chk_branch_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
		monReg |-> intPinForBranch == intPinLevel) else $error("branch pin view wrong");
	chk_forced_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
		forcedReg |=> forcedReg) else $error("forced flag lost");
	chk_reenter_mon: assert property (@(posedge clk_sys) disable iff (!nrst)
		(forcedReg && !coreReset) |-> monReg) else $error("left forced monitor");
	chk_mon_page: assert property (@(posedge clk_sys) disable iff (!nrst)
		(monReg && vecFetch && stateReg == fmm_pkg::ST_RUN) |-> memAddr[15:8] == 8'hFE) else $error("wrong page");
	cov_forced: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(forcedReg));
	cov_user: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(coreReset) && !monReg);
	cov_rerst: cover property (@(posedge clk_sys) disable iff (!nrst) forcedReg && !otherRst_n);
	cov_extra_done: cover property (@(posedge clk_sys) disable iff (!nrst) extraDoneReg && !coreReset);
endmodule

// [rtl/fmm_reset_counter.sv]
`timescale 1ns/10ps
module fmm_reset_counter #(
	parameter logic [3:0] CYCLES = 4'h8
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic nrst,
	// Control
	input  wire logic start,
	output logic      done
);
	logic [3:0] countReg;
	logic [3:0] countNext;

	// Load on start, count down to zero
	always_comb begin
		countNext = countReg;
		if (start) begin
			countNext = CYCLES;
		end else if (countReg != 4'h0) begin
			countNext = countReg - 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			countReg <= 4'h0;
		end else begin
			countReg <= countNext;
		end
	end

	assign done = (countReg == 4'h1);
endmodule

// [shared/fmm_pkg.sv]
// Function
// - Watch reset vector fetches; erased bytes trigger internal reset then monitor entry.
// - Forced entry ignores startup strap pin level conditions.
// - Blank vector entry adds one extra reset cycle after power-on reset.
// - Liveness watchdog held disabled whenever monitor mode was forced.
// - Forced entry runs monitor firmware on default internal oscillator setting.
// - Forced, interrupt pin high: inputs except serial pin and external clock pin.
// - Forced, interrupt pin low: inputs except the monitor serial pin.
// - In monitor mode interrupt pin is no port input; port A bit 2 reads zero.
// - In monitor mode interrupt pin branches act as though the pin were enabled.
// - Any non power-on reset in forced monitor returns to forced monitor.
// - Monitor mode fetches reset, soft trap and break vectors from alternate page.
// - Only power-on reset leaves blank-vector monitor mode; reset pin does not.
// - Vectors: user FFFE/FFFF and FFFC/FFFD; monitor FEFE/FEFF and FEFC/FEFD.
// - Below test voltage the device leaves reset in user mode unless forced.
package fmm_pkg;

	// ----------------------------------------
	// Vector addresses
	// ----------------------------------------
	localparam logic [7:0]  USER_PAGE      = 8'hFF;
	localparam logic [7:0]  MON_PAGE       = 8'hFE;
	localparam logic [7:0]  RESET_VEC_LO   = 8'hFE;
	localparam logic [7:0]  TRAP_VEC_LO    = 8'hFC;
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
	localparam logic [15:0] USER_RESET_VEC = 16'hFFFE;

	// ----------------------------------------
	// Pin bits and timing
	// ----------------------------------------
	localparam int          SERIAL_BIT     = 0;
	localparam int          IRQ_BIT        = 2;
	localparam int          EXTCLK_BIT     = 5;
	localparam int          PORT_W         = 6;
	localparam logic [3:0]  RESET_CYCLES   = 4'h8;
	localparam logic [3:0]  OSC_TRIM_DEF   = 4'h8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_RESET  = 3'b000,
		ST_FETCHH = 3'b001,
		ST_FETCHL = 3'b010,
		ST_INTRST = 3'b011,
		ST_RUN    = 3'b100
	} fmm_state_t;

	typedef struct packed {
		logic       monitorMode;
		logic       forcedMonitor;
		logic       watchdogDisable;
		logic       oscDefault;
		logic       strapCheckEn;
	} fmm_mode_t;

	typedef struct packed {
		logic [PORT_W-1:0] pinInputOnly;
		logic              serialEn;
		logic              extClockEn;
	} fmm_pins_t;

endpackage
